// *** hdl/sgcrd_byte_merge.sv ***
`timescale 1ns/1ns
module sgcrd_byte_merge (
    input  wire logic [15:0] i_old,
    input  wire logic [15:0] i_new,
    input  wire logic [1:0]  i_mask,
    output logic      [15:0] o_word
);
    // a high mask keeps the stored byte
    assign o_word = {i_mask[1] ? i_old[15:8] : i_new[15:8],
                     i_mask[0] ? i_old[7:0]  : i_new[7:0]}; // RULE19
endmodule

// *** hdl/sgcrd_ctrl.sv ***
`timescale 1ns/1ns
`include "sgcrd_params.svh"
module sgcrd_ctrl (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    sgcrd_if.ctrl            bus,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata
);
    typedef struct packed {
        sgcrd_pkg::sgcrd_hst_t        fsm;
        sgcrd_pkg::sgcrd_cmd_t        qcmd;
        logic [1:0]                   qba;
        logic [12:0]                  qaddr;
        logic [15:0]                  qdata;
        logic [1:0]                   qmask;
        logic                         ref_en;
        logic [12:0]                  ref_tmr;
        logic [3:0]                   owed;
        logic [7:0]                   wait_c;
        logic [3:0][3:0]              bank_tmr;
        logic [1:0]                   rrd;
        logic [3:0]                   open;
        logic                         exit_req;
        logic                         self_go;
        logic                         cke;
        logic [3:0]                   pins;
        logic [1:0]                   ba;
        logic [12:0]                  addr;
        logic                         wvalid;
        logic [31:0]                  rdata;
    } sgcrd_ctl_st_t;

    sgcrd_ctl_st_t st_r;
    sgcrd_ctl_st_t st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.pins   = 4'hf;
        st_nxt.wvalid = 1'b0;
        st_nxt.rdata  = 32'h0000_0000;
        st_nxt.cke    = 1'b1; // RULE13
        if (st_r.rrd != 2'h0) st_nxt.rrd = st_r.rrd - 2'h1;
        for (int b = 0; b < 4; b++) begin
            if (st_r.bank_tmr[b] != 4'h0) st_nxt.bank_tmr[b] = st_r.bank_tmr[b] - 4'h1;
        end
        if (st_r.ref_en && st_r.fsm != sgcrd_pkg::SGCRD_H_SELF) begin
            if (st_r.ref_tmr == 13'(`SGCRD_REFI_CYC - 1)) begin
                st_nxt.ref_tmr = 13'h0000;
                st_nxt.owed    = st_r.owed + 4'h1; // RULE3
            end else begin
                st_nxt.ref_tmr = st_r.ref_tmr + 13'h0001;
            end
        end
        if (i_wr) begin
            unique case (i_addr)
                `SGCRD_REG_CMD: begin
                    st_nxt.ref_en = i_wdata[`SGCRD_CMD_REF_EN_BIT];
                    if (i_wdata[`SGCRD_CMD_EXIT_BIT]) st_nxt.exit_req = 1'b1;
                    if (i_wdata[`SGCRD_CMD_GO_BIT] && st_r.fsm == sgcrd_pkg::SGCRD_H_IDLE) begin
                        st_nxt.qcmd  = sgcrd_pkg::sgcrd_cmd_t'(i_wdata[6:4]);
                        st_nxt.qba   = i_wdata[9:8];
                        st_nxt.qmask = i_wdata[13:12];
                        st_nxt.self_go = 1'b0;
                        st_nxt.fsm   = sgcrd_pkg::SGCRD_H_ISSUE;
                    end
                    if (i_wdata[`SGCRD_CMD_SELF_BIT] && st_r.fsm == sgcrd_pkg::SGCRD_H_IDLE) begin
                        st_nxt.qcmd = sgcrd_pkg::SGCRD_REFRESH;
                        st_nxt.qba  = 2'b11;
                        st_nxt.self_go = 1'b1;
                        st_nxt.fsm  = sgcrd_pkg::SGCRD_H_ISSUE;
                    end
                end
                `SGCRD_REG_ADDR: begin
                    st_nxt.qaddr = i_wdata[12:0];
                    st_nxt.qdata = i_wdata[31:16];
                end
                default: begin
                end
            endcase
        end
        if (i_rd) begin
            unique case (i_addr)
                `SGCRD_REG_STATUS: st_nxt.rdata = {20'h0_0000, st_r.owed, st_r.open, 1'b0, st_r.fsm};
                `SGCRD_REG_ADDR:   st_nxt.rdata = {st_r.qdata, 3'h0, st_r.qaddr};
                default:           st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        unique case (st_r.fsm)
            sgcrd_pkg::SGCRD_H_IDLE: begin
                if (st_r.owed != 4'h0 && st_r.open == 4'h0) begin
                    st_nxt.pins = {1'b0, 3'b001}; // RULE1 RULE4
                    st_nxt.owed = st_nxt.owed - 4'h1;
                end else if (st_r.owed >= 4'(`SGCRD_MAX_POSTPONE) && st_r.open != 4'h0) begin
                    st_nxt.pins = {1'b0, 3'b010}; // RULE4
                    st_nxt.addr = 13'h0400;
                    st_nxt.open = 4'h0;
                end
            end
            sgcrd_pkg::SGCRD_H_ISSUE: begin
                st_nxt.ba   = st_r.qba;
                st_nxt.addr = st_r.qaddr;
                st_nxt.fsm  = sgcrd_pkg::SGCRD_H_IDLE;
                unique case (st_r.qcmd)
                    sgcrd_pkg::SGCRD_ROW_OPEN: begin
                        if (st_r.open[st_r.qba] || st_r.bank_tmr[st_r.qba] != 4'h0 || st_r.rrd != 2'h0) begin
                            st_nxt.fsm = sgcrd_pkg::SGCRD_H_ISSUE; // RULE21 RULE22
                        end else begin
                            st_nxt.pins               = 4'b0011;
                            st_nxt.open[st_r.qba]     = 1'b1;
                            st_nxt.bank_tmr[st_r.qba] = 4'(`SGCRD_ROW_CYCLE_CYC);
                            st_nxt.rrd                = 2'(`SGCRD_BANK_BANK_CYC);
                            st_nxt.wait_c             = 8'(`SGCRD_ROW_TO_COL_CYC); // RULE20
                            st_nxt.fsm                = sgcrd_pkg::SGCRD_H_WAIT;
                        end
                    end
                    sgcrd_pkg::SGCRD_READ, sgcrd_pkg::SGCRD_WRITE: begin
                        if (!st_r.open[st_r.qba]) begin
                            st_nxt.fsm = sgcrd_pkg::SGCRD_H_IDLE; // RULE20
                        end else begin
                            st_nxt.pins = {1'b0, st_r.qcmd};
                            st_nxt.wvalid = (st_r.qcmd == sgcrd_pkg::SGCRD_WRITE);
                            if (st_r.qaddr[10]) st_nxt.open[st_r.qba] = 1'b0;
                        end
                    end
                    sgcrd_pkg::SGCRD_REFRESH: begin
                        if (st_r.open != 4'h0) begin
                            st_nxt.pins = 4'b0010;
                            st_nxt.addr = 13'h0400;
                            st_nxt.open = 4'h0;
                            st_nxt.fsm  = sgcrd_pkg::SGCRD_H_ISSUE;
                        end else if (st_r.self_go) begin
                            st_nxt.pins     = 4'b0001;
                            st_nxt.cke      = 1'b0; // RULE5
                            st_nxt.exit_req = i_wr && i_addr == `SGCRD_REG_CMD && i_wdata[`SGCRD_CMD_EXIT_BIT];
                            st_nxt.fsm      = sgcrd_pkg::SGCRD_H_SELF;
                        end else begin
                            st_nxt.pins = 4'b0001; // RULE1 RULE13
                        end
                    end
                    sgcrd_pkg::SGCRD_PRECHARGE: begin
                        st_nxt.pins = 4'b0010;
                        if (st_r.qaddr[10]) st_nxt.open = 4'h0;
                        else st_nxt.open[st_r.qba] = 1'b0;
                    end
                    default: begin
                        // burst stop sent as queued, whatever the previous read was
                        st_nxt.pins = {1'b0, st_r.qcmd}; // RULE16
                    end
                endcase
            end
            sgcrd_pkg::SGCRD_H_WAIT: begin
                if (st_r.wait_c <= 8'h01) st_nxt.fsm = sgcrd_pkg::SGCRD_H_IDLE;
                else st_nxt.wait_c = st_r.wait_c - 8'h01;
            end
            sgcrd_pkg::SGCRD_H_SELF: begin
                st_nxt.cke = 1'b0;
                if (st_r.exit_req) begin
                    // clock runs throughout, so it is stable at exit
                    st_nxt.cke    = 1'b1; // RULE8
                    st_nxt.wait_c = 8'(`SGCRD_EXIT_NOP_CYC); // RULE7 RULE10
                    st_nxt.fsm    = sgcrd_pkg::SGCRD_H_EXIT;
                end
            end
            sgcrd_pkg::SGCRD_H_EXIT: begin
                if (st_r.wait_c <= 8'h01) st_nxt.fsm = sgcrd_pkg::SGCRD_H_IDLE; // RULE9
                else st_nxt.wait_c = st_r.wait_c - 8'h01;
            end
            default: st_nxt.fsm = sgcrd_pkg::SGCRD_H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r      <= '0;
            st_r.pins <= 4'hf;
            st_r.cke  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.cke        = st_r.cke;
    assign bus.cs_n       = st_r.pins[3];
    assign bus.ras_n      = st_r.pins[2];
    assign bus.cas_n      = st_r.pins[1];
    assign bus.we_n       = st_r.pins[0];
    assign bus.bank_sel_0 = st_r.ba[0];
    assign bus.bank_sel_1 = st_r.ba[1];
    assign bus.addr       = st_r.addr;
    assign bus.wdata      = st_r.qdata;
    assign bus.write_mask = st_r.qmask;
    assign bus.wvalid     = st_r.wvalid;
    assign o_rdata        = st_r.rdata;
endmodule

// *** hdl/sgcrd_device.sv ***
`timescale 1ns/1ns
`include "sgcrd_params.svh"
module sgcrd_device (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    sgcrd_if.dev             bus,
    output logic [3:0]       o_bank_active,
    output logic [51:0]      o_open_rows,
    output logic             o_self_refresh,
    output logic             o_dll_on,
    output logic [12:0]      o_refresh_row,
    output logic [12:0]      o_mode_base,
    output logic [12:0]      o_mode_ext,
    output logic [15:0]      o_last_word,
    output logic [8:0]       o_last_col
);
    typedef struct packed {
        sgcrd_pkg::sgcrd_bank_t [3:0] bank;
        logic [3:0][12:0]            row;
        logic [3:0][2:0]             cnt;
        logic [3:0]                  ap;
        logic                        self_r;
        logic                        dll;
        logic [12:0]                 refc;
        logic [12:0]                 mb;
        logic [12:0]                 me;
        logic [15:0]                 word;
        logic [8:0]                  col;
    } sgcrd_dev_st_t;

    sgcrd_dev_st_t      st_r;
    sgcrd_dev_st_t      st_nxt;
    sgcrd_pkg::sgcrd_cmd_t cmd;
    logic [1:0]         ba;
    logic [15:0]        merged;

    assign ba  = {bus.bank_sel_1, bus.bank_sel_0};
    assign cmd = sgcrd_pkg::sgcrd_decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n); // RULE11 RULE12

    sgcrd_byte_merge u_merge (
        .i_old  (st_r.word),
        .i_new  (bus.wdata),
        .i_mask (bus.write_mask),
        .o_word (merged)
    );

    always_comb begin
        st_nxt = st_r;
        // burst-end auto close and precharge completion
        for (int b = 0; b < 4; b++) begin
            if (st_r.cnt[b] != 3'h0) begin
                st_nxt.cnt[b] = st_r.cnt[b] - 3'h1;
                if (st_r.cnt[b] == 3'h1) begin
                    if (st_r.bank[b] == sgcrd_pkg::SGCRD_ACTIVE && st_r.ap[b]) begin
                        st_nxt.bank[b] = sgcrd_pkg::SGCRD_CLOSING; // RULE24
                        st_nxt.cnt[b]  = 3'(`SGCRD_PRECH_CYC);
                        st_nxt.ap[b]   = 1'b0;
                    end else if (st_r.bank[b] == sgcrd_pkg::SGCRD_CLOSING) begin
                        st_nxt.bank[b] = sgcrd_pkg::SGCRD_IDLE; // RULE24
                    end
                end
            end
        end
        if (!st_r.self_r && bus.wvalid && cmd == sgcrd_pkg::SGCRD_WRITE) begin
            st_nxt.word = merged; // RULE19
        end
        if (st_r.self_r) begin
            // only clock enable is watched in self refresh
            if (bus.cke) begin
                st_nxt.self_r = 1'b0;
                st_nxt.dll    = 1'b1; // RULE7
            end else begin
                st_nxt.refc = st_r.refc + 13'h0001; // RULE6
            end
        end else begin
            unique case (cmd)
                sgcrd_pkg::SGCRD_ROW_OPEN: begin
                    st_nxt.bank[ba] = sgcrd_pkg::SGCRD_ACTIVE; // RULE14 RULE24
                    st_nxt.row[ba]  = bus.addr;
                    st_nxt.cnt[ba]  = 3'h0;
                end
                sgcrd_pkg::SGCRD_READ, sgcrd_pkg::SGCRD_WRITE: begin
                    st_nxt.col     = bus.addr[8:0]; // RULE15
                    st_nxt.ap[ba]  = bus.addr[10];
                    st_nxt.cnt[ba] = 3'(`SGCRD_BURST_CYC);
                end
                sgcrd_pkg::SGCRD_PRECHARGE: begin
                    for (int b = 0; b < 4; b++) begin
                        if ((bus.addr[10] || ba == 2'(b)) && st_r.bank[b] == sgcrd_pkg::SGCRD_ACTIVE) begin // RULE17 RULE23
                            st_nxt.bank[b] = sgcrd_pkg::SGCRD_CLOSING;
                            st_nxt.cnt[b]  = 3'(`SGCRD_PRECH_CYC);
                            st_nxt.ap[b]   = 1'b0;
                        end
                    end
                end
                sgcrd_pkg::SGCRD_REFRESH: begin
                    st_nxt.refc = st_r.refc + 13'h0001; // RULE2
                    if (!bus.cke) begin
                        st_nxt.self_r = 1'b1; // RULE5 RULE13
                        st_nxt.dll    = 1'b0; // RULE7
                    end
                end
                sgcrd_pkg::SGCRD_MODE_LOAD: begin
                    if (ba == 2'b00) begin
                        st_nxt.mb = bus.addr; // RULE18
                    end else if (ba == 2'b01) begin
                        st_nxt.me = bus.addr; // RULE18
                    end
                end
                sgcrd_pkg::SGCRD_BURST_STOP: begin
                end
                sgcrd_pkg::SGCRD_NOP: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_r     <= '0;
            st_r.dll <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            o_bank_active[b] = (st_r.bank[b] == sgcrd_pkg::SGCRD_ACTIVE);
        end
    end
    assign o_open_rows    = st_r.row;
    assign o_self_refresh = st_r.self_r;
    assign o_dll_on       = st_r.dll;
    assign o_refresh_row  = st_r.refc;
    assign o_mode_base    = st_r.mb;
    assign o_mode_ext     = st_r.me;
    assign o_last_word    = st_r.word;
    assign o_last_col     = st_r.col;
endmodule

// *** hdl/sgcrd_if.sv ***
`timescale 1ns/1ns
interface sgcrd_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bank_sel_0;
    logic        bank_sel_1;
    logic [12:0] addr;
    logic [15:0] wdata;
    logic [1:0]  write_mask;
    logic        wvalid;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_sel_0, bank_sel_1, addr, wdata, write_mask, wvalid);
    modport dev  (input  cke, cs_n, ras_n, cas_n, we_n, bank_sel_0, bank_sel_1, addr, wdata, write_mask, wvalid);
endinterface

// *** hdl/sgcrd_params.svh ***
`ifndef SGCRD_PARAMS_SVH
`define SGCRD_PARAMS_SVH
// Summary of operation
// RULE1: controller issues one refresh per needed refresh
// RULE2: refresh uses internal counter, ignores address
// RULE3: average refresh spacing at most 7.8 us
// RULE4: up to eight postponed, gap nine intervals
// RULE5: refresh with clock enable low enters self
// RULE6: self refresh ignores all but clock enable
// RULE7: loop off in self; 200 cycles before read
// RULE8: clock stable before raising clock enable
// RULE9: only no-ops during self exit wait
// RULE10: no-ops for 200 cycles after exit
// RULE11: decode strobes under chip select low
// RULE12: deselect acts exactly like no-op
// RULE13: clock enable high except self entry
// RULE14: activate uses bank select and row
// RULE15: column from low bits; auto close bit
// RULE16: burst stop only on plain reads; controller sends it without checking the last read
// RULE17: precharge one bank or all banks
// RULE18: mode load picks base or extended register
// RULE19: masked bytes are not written
// RULE20: activate row before access, wait delay
// RULE21: precharge before new row; row cycle time
// RULE22: other bank activates spaced by delay
// RULE23: precharge of idle bank is no-op
// RULE24: track per-bank state and open row

`define SGCRD_CLK_PERIOD_NS   4
`define SGCRD_REFI_NS         7800
`define SGCRD_REFI_CYC        (`SGCRD_REFI_NS / `SGCRD_CLK_PERIOD_NS)
`define SGCRD_MAX_POSTPONE    8
`define SGCRD_DLL_WAIT_CYC    200
`define SGCRD_EXIT_NOP_CYC    200
`define SGCRD_ROW_TO_COL_CYC  3
`define SGCRD_ROW_CYCLE_CYC   10
`define SGCRD_BANK_BANK_CYC   2
`define SGCRD_PRECH_CYC       3
`define SGCRD_BURST_CYC       4
`define SGCRD_ROWS            8192
`define SGCRD_REG_CMD         4'h0
`define SGCRD_REG_ADDR        4'h1
`define SGCRD_REG_STATUS      4'h2
`define SGCRD_REG_DEV         4'h3
`define SGCRD_CMD_GO_BIT      0
`define SGCRD_CMD_BUSY_BIT    0
`define SGCRD_CMD_SELF_BIT    1
`define SGCRD_CMD_EXIT_BIT    2
`define SGCRD_CMD_REF_EN_BIT  3
`endif

// *** hdl/sgcrd_pkg.sv ***
package sgcrd_pkg;
    typedef enum logic [2:0] {
        SGCRD_MODE_LOAD, SGCRD_REFRESH, SGCRD_PRECHARGE, SGCRD_ROW_OPEN,
        SGCRD_WRITE, SGCRD_READ, SGCRD_BURST_STOP, SGCRD_NOP
    } sgcrd_cmd_t;
    typedef enum logic [1:0] {SGCRD_IDLE, SGCRD_ACTIVE, SGCRD_CLOSING} sgcrd_bank_t;
    typedef enum logic [2:0] {SGCRD_H_IDLE, SGCRD_H_ISSUE, SGCRD_H_WAIT, SGCRD_H_SELF, SGCRD_H_EXIT} sgcrd_hst_t;

    function automatic sgcrd_cmd_t sgcrd_decode(input logic cs_n, input logic ras_n,
                                                input logic cas_n, input logic we_n);
        if (cs_n) begin
            return SGCRD_NOP;
        end
        return sgcrd_cmd_t'({ras_n, cas_n, we_n});
    endfunction
endpackage

// *** verif/sgcrd_sva.sv ***
`timescale 1ns/1ns
module sgcrd_sva (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic        bank_sel_0,
    input wire logic        bank_sel_1,
    input wire logic [12:0] addr,
    input wire logic        wvalid
);
    // ====================
    // wire decode
    logic [2:0] pin;
    logic [1:0] ba;
    logic       nop;
    logic       is_act;
    logic       is_rw;
    logic       is_wr;
    logic       is_ref;
    logic       is_pre;
    logic       is_bst;
    logic [3:0] open_r;
    logic [7:0] exit_r;
    logic       rd_ap_r;
    logic [3:0] rc_r [4];
    assign pin    = {ras_n, cas_n, we_n};
    assign ba     = {bank_sel_1, bank_sel_0};
    assign nop    = cs_n || pin == 3'h7;
    assign is_act = !cs_n && pin == 3'h3;
    assign is_wr  = !cs_n && pin == 3'h4;
    assign is_rw  = !cs_n && pin[2:1] == 2'h2;
    assign is_ref = !cs_n && pin == 3'h1;
    assign is_pre = !cs_n && pin == 3'h2;
    assign is_bst = !cs_n && pin == 3'h6;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            open_r  <= 4'h0;
            exit_r  <= 8'h00;
            rd_ap_r <= 1'b1;
            for (int b = 0; b < 4; b++) begin
                rc_r[b] <= 4'h0;
            end
        end else begin
            if ($rose(cke)) begin
                exit_r <= 8'hc7;
            end else if (exit_r != 8'h00) begin
                exit_r <= exit_r - 8'h01;
            end
            if (!cs_n && pin == 3'h5) begin
                rd_ap_r <= addr[10];
            end
            if (is_act) begin
                open_r[ba] <= 1'b1;
            end else if (is_pre && addr[10]) begin
                open_r <= 4'h0;
            end else if (is_pre || (is_rw && addr[10])) begin
                open_r[ba] <= 1'b0;
            end
            for (int b = 0; b < 4; b++) begin
                if (is_act && ba == b[1:0]) begin
                    rc_r[b] <= 4'h9;
                end else if (rc_r[b] != 4'h0) begin
                    rc_r[b] <= rc_r[b] - 4'h1;
                end
            end
        end
    end
    // ====================
    // properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_act;
        is_act;
    endsequence
    sequence s_self_entry;
        is_ref && !cke;
    endsequence
    a_cke_fall_ref: assert property ($fell(cke) |-> s_self_entry)
        else $error("clock enable fell without refresh");
    a_cke_low_cmd: assert property (!cke && !nop |-> $fell(cke) && is_ref)
        else $error("command with clock enable low");
    a_exit_nop_wait: assert property ($rose(cke) || exit_r != 8'h00 |-> nop)
        else $error("command inside self exit wait");
    a_row_col_wait: assert property (is_rw |-> open_r[ba] && !($past(is_act) && $past(ba) == ba)
        && !($past(is_act, 2) && $past(ba, 2) == ba))
        else $error("access too soon or to closed bank");
    a_bank_bank_gap: assert property (s_act |=> !is_act)
        else $error("activates too close");
    a_row_cycle_min: assert property (s_act |-> rc_r[ba] == 4'h0)
        else $error("same bank activates too close");
    a_act_after_pre: assert property (s_act |-> !open_r[ba])
        else $error("activate to bank with open row");
    a_bst_plain_read: assert property (is_bst |-> !rd_ap_r)
        else $error("burst stop after auto close read");
    a_write_data_pair: assert property (wvalid || is_wr |-> wvalid && is_wr)
        else $error("write data not paired with write");
endmodule

// *** verif/sgram_command_refresh_decode_tb_top.sv ***
`timescale 1ns/1ns
`include "sgcrd_params.svh"
module sgram_command_refresh_decode_tb_top;
    // ====================
    // signals
    logic        i_clk;
    logic        i_arst_n;
    logic [3:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic [3:0]  o_bank_active;
    logic [51:0] o_open_rows;
    logic        o_self_refresh;
    logic        o_dll_on;
    logic [12:0] o_refresh_row;
    logic [12:0] o_mode_base;
    logic [12:0] o_mode_ext;
    logic [15:0] o_last_word;
    logic [8:0]  o_last_col;
    logic [31:0] rd_v;
    logic [12:0] rr;
    int          n;
    int          bad_count;
    int          n_compared;
    logic [15:0] wd [3] = '{16'h1234, 16'habcd, 16'h5678};
    logic [1:0]  wm [3] = '{2'h0, 2'h2, 2'h1};
    logic [15:0] wx [3] = '{16'h1234, 16'h12cd, 16'h56cd};
    sgcrd_if bus_if ();
    sgcrd_ctrl u_sgcrd_ctrl (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus_if), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    sgcrd_device u_sgcrd_device (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus_if),
        .o_bank_active(o_bank_active), .o_open_rows(o_open_rows), .o_self_refresh(o_self_refresh),
        .o_dll_on(o_dll_on), .o_refresh_row(o_refresh_row), .o_mode_base(o_mode_base),
        .o_mode_ext(o_mode_ext), .o_last_word(o_last_word), .o_last_col(o_last_col));
    sgcrd_sva u_sgcrd_sva (.i_clk(i_clk), .i_arst_n(i_arst_n), .cke(bus_if.cke), .cs_n(bus_if.cs_n),
        .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n), .we_n(bus_if.we_n), .bank_sel_0(bus_if.bank_sel_0),
        .bank_sel_1(bus_if.bank_sel_1), .addr(bus_if.addr), .wvalid(bus_if.wvalid));
    always #2 i_clk = ~i_clk;
    // ====================
    // tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic reg_rd(input logic [3:0] a);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        rd_v = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic wait_fsm(input logic [2:0] v);
        int k;
        k = 0;
        repeat (3) @(posedge i_clk);
        reg_rd(4'h2);
        while (rd_v[2:0] !== v && k < 400) begin
            reg_rd(4'h2);
            k++;
        end
        if (rd_v[2:0] !== v) begin
            chk("fsm_state", v, rd_v[2:0]);
            give_verdict();
        end
        repeat (3) @(posedge i_clk);
    endtask
    task automatic cmd(input sgcrd_pkg::sgcrd_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d, input logic [1:0] m);
        reg_wr(4'h1, {d, 3'h0, a});
        reg_wr(4'h0, {18'h0_0000, m, 2'h0, b, 1'h0, c, 4'h1});
        wait_fsm(sgcrd_pkg::SGCRD_H_IDLE);
    endtask
    // ====================
    // sequence
    initial begin
        i_clk      = 1'b0;
        i_arst_n   = 1'b0;
        i_addr     = 4'h0;
        i_wdata    = 32'h0000_0000;
        i_wr       = 1'b0;
        i_rd       = 1'b0;
        bad_count  = 0;
        n_compared = 0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        chk("dll_on", 1, o_dll_on);
        chk("bank_active", 0, o_bank_active);
        reg_rd(4'hf);
        chk("unmapped_read", 0, rd_v);
        for (int b = 0; b < 4; b++) begin
            cmd(sgcrd_pkg::SGCRD_MODE_LOAD, b[1:0], 13'h0100 + 13'(b), 16'h0000, 2'h0);
            chk("mode_base", 32'h0100, o_mode_base);
            chk("mode_ext", (b == 0) ? 32'h0 : 32'h0101, o_mode_ext);
        end
        cmd(sgcrd_pkg::SGCRD_REFRESH, 2'h3, 13'h1fff, 16'h0000, 2'h0);
        chk("refresh_row", 1, o_refresh_row);
        cmd(sgcrd_pkg::SGCRD_ROW_OPEN, 2'h1, 13'h1abc, 16'h0000, 2'h0);
        cmd(sgcrd_pkg::SGCRD_ROW_OPEN, 2'h2, 13'h0155, 16'h0000, 2'h0);
        chk("bank_active", 4'h6, o_bank_active);
        chk("row_b1", 13'h1abc, o_open_rows[25:13]);
        chk("row_b2", 13'h0155, o_open_rows[38:26]);
        for (int k = 0; k < 3; k++) begin
            cmd(sgcrd_pkg::SGCRD_WRITE, 2'h1, 13'h08a5, wd[k], wm[k]);
            chk("last_word", wx[k], o_last_word);
        end
        chk("last_col", 9'h0a5, o_last_col);
        cmd(sgcrd_pkg::SGCRD_READ, 2'h1, 13'h00a5, 16'h0000, 2'h0);
        cmd(sgcrd_pkg::SGCRD_BURST_STOP, 2'h1, 13'h0000, 16'h0000, 2'h0);
        chk("bank_active", 4'h6, o_bank_active);
        cmd(sgcrd_pkg::SGCRD_READ, 2'h1, 13'h04a5, 16'h0000, 2'h0);
        repeat (10) @(posedge i_clk);
        chk("bank_active", 4'h4, o_bank_active);
        cmd(sgcrd_pkg::SGCRD_ROW_OPEN, 2'h0, 13'h0005, 16'h0000, 2'h0);
        cmd(sgcrd_pkg::SGCRD_PRECHARGE, 2'h3, 13'h0000, 16'h0000, 2'h0);
        repeat (10) @(posedge i_clk);
        chk("bank_active", 4'h5, o_bank_active);
        cmd(sgcrd_pkg::SGCRD_PRECHARGE, 2'h0, 13'h0000, 16'h0000, 2'h0);
        repeat (10) @(posedge i_clk);
        chk("bank_active", 4'h4, o_bank_active);
        cmd(sgcrd_pkg::SGCRD_PRECHARGE, 2'h0, 13'h0400, 16'h0000, 2'h0);
        repeat (10) @(posedge i_clk);
        chk("bank_active", 4'h0, o_bank_active);
        cmd(sgcrd_pkg::SGCRD_ROW_OPEN, 2'h2, 13'h0777, 16'h0000, 2'h0);
        chk("row_b2", 13'h0777, o_open_rows[38:26]);
        reg_wr(4'h0, 32'h0000_0002);
        wait_fsm(sgcrd_pkg::SGCRD_H_SELF);
        chk("self_refresh", 1, o_self_refresh);
        chk("dll_on", 0, o_dll_on);
        reg_wr(4'h0, 32'h0000_0004);
        wait_fsm(sgcrd_pkg::SGCRD_H_IDLE);
        chk("self_refresh", 0, o_self_refresh);
        chk("dll_on", 1, o_dll_on);
        cmd(sgcrd_pkg::SGCRD_ROW_OPEN, 2'h3, 13'h0033, 16'h0000, 2'h0);
        chk("bank3_open", 1, o_bank_active[3]);
        rr = o_refresh_row;
        reg_wr(4'h0, 32'h0000_0008);
        for (n = 0; n < 9 * `SGCRD_REFI_CYC && o_refresh_row === rr; n++) @(posedge i_clk);
        chk("refresh_due", 1, n < 9 * `SGCRD_REFI_CYC);
        reg_rd(4'h2);
        chk("owed_bound", 1, rd_v[11:8] <= 4'h8);
        reg_wr(4'h0, 32'h0000_0000);
        give_verdict();
    end
endmodule
